/* File: design/tc8_clksel.sv */
// Timer clock select: source choice and prescaler, one-cycle tick enable
`timescale 1ns/1ps
module tc8_clksel
  import tc8_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  tc8_if.clk       ck
);

  logic       xtal_r;
  logic       xtal_nxt;
  logic [9:0] pre_r;
  logic [9:0] pre_nxt;
  logic       src_ev;
  logic       hit;

  always_comb begin
    xtal_nxt = ck.xtal;
    // crystal edge caught as an enable in the core clock domain
    src_ev = ck.async_sel ? (ck.xtal & ~xtal_r) : 1'b1;
    hit = (pre_r & tc8_div_mask(ck.cs)) == tc8_div_mask(ck.cs);
    pre_nxt = pre_r;
    if (ck.cs != TC8_CS_STOP && src_ev) begin
      pre_nxt = pre_r + TC8_PRE_ONE;
    end
  end

  assign ck.tick = (ck.cs != TC8_CS_STOP) && src_ev && hit;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      xtal_r <= 1'b0;
      pre_r  <= TC8_PRE_RST;
    end else begin
      xtal_r <= xtal_nxt;
      pre_r  <= pre_nxt;
    end
  end

endmodule // tc8_clksel

/* File: design/tc8_if.sv */
// Internal links between counter core, clock select and waveform unit
`timescale 1ns/1ps
interface tc8_if;
  import tc8_pkg::*;
  logic     tick;
  logic     cmp_ev;
  logic     force_ev;
  logic     at_max;
  tc8_dir_t dir;
  tc8_wgm_t wgm;
  tc8_com_t com;
  logic     oc;
  logic [2:0] cs;
  logic     async_sel;
  logic     xtal;

  modport ctr (output cmp_ev, force_ev, at_max, dir, wgm, com, cs,
               output async_sel, xtal, input tick, oc);
  modport clk (input cs, async_sel, xtal, output tick);
  modport wav (input tick, cmp_ev, force_ev, at_max, dir, wgm, com,
               output oc);
endinterface

/* File: design/tc8_pkg.sv */
// Shared constants, types and decode functions of the 8-bit timer
package tc8_pkg;

  localparam logic [7:0] TC8_BOTTOM   = 8'h00;
  localparam logic [7:0] TC8_MAX      = 8'hff;
  localparam logic [7:0] TC8_ONE      = 8'h01;
  localparam logic [7:0] TC8_CNT_RST  = 8'h00;
  localparam logic [7:0] TC8_CMP_RST  = 8'h00;
  localparam logic [2:0] TC8_CS_STOP  = 3'h0;
  localparam logic [9:0] TC8_PRE_ONE  = 10'h001;
  localparam logic [9:0] TC8_PRE_RST  = 10'h000;

  typedef enum logic [1:0] {
    TC8_WGM_NORMAL   = 2'b00,
    TC8_WGM_PHASE    = 2'b01,
    TC8_WGM_CLRMATCH = 2'b10,
    TC8_WGM_FAST     = 2'b11
  } tc8_wgm_t;

  typedef enum logic [1:0] {
    TC8_COM_OFF    = 2'b00,
    TC8_COM_TOGGLE = 2'b01,
    TC8_COM_CLEAR  = 2'b10,
    TC8_COM_SET    = 2'b11
  } tc8_com_t;

  typedef enum logic {
    TC8_DIR_UP   = 1'b0,
    TC8_DIR_DOWN = 1'b1
  } tc8_dir_t;

  // Prescaler tap mask per clock source select code
  function automatic logic [9:0] tc8_div_mask(input logic [2:0] cs);
    case (cs)
      3'h2:    return 10'h007;
      3'h3:    return 10'h01f;
      3'h4:    return 10'h03f;
      3'h5:    return 10'h07f;
      3'h6:    return 10'h0ff;
      3'h7:    return 10'h3ff;
      default: return 10'h000;
    endcase
  endfunction

  function automatic logic tc8_is_pwm(input tc8_wgm_t m);
    return (m == TC8_WGM_PHASE) || (m == TC8_WGM_FAST);
  endfunction

endpackage

/* File: design/tc8_timer.sv */
// Top of the 8-bit timer/counter with one compare channel
`timescale 1ns/1ps

module tc8_timer
  import tc8_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] waveform_mode,
  input  wire logic [1:0] compare_output_mode,
  input  wire logic [2:0] clock_source_select,
  input  wire logic       async_clock_select,
  input  wire logic       crystal_pin_in,
  input  wire logic       compare_irq_enable,
  input  wire logic       overflow_irq_enable,
  input  wire logic       force_compare_strobe,
  input  wire logic       counter_wr_en,
  input  wire logic [7:0] counter_wr_data,
  input  wire logic       compare_wr_en,
  input  wire logic [7:0] compare_wr_data,
  input  wire logic       compare_flag_clr,
  input  wire logic       overflow_flag_clr,
  input  wire logic       compare_irq_ack,
  input  wire logic       overflow_irq_ack,
  output logic      [7:0] counter_value,
  output logic      [7:0] compare_value,
  output logic            compare_match_flag,
  output logic            overflow_flag,
  output logic            compare_irq,
  output logic            overflow_irq,
  output logic            compare_output_pin
);

  // ********************************************
  // State
  // ********************************************
  // 8-bit counter and compare
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  tc8_dir_t   dir_r;
  tc8_dir_t   dir_nxt;
  logic [7:0] buf_r;
  logic [7:0] buf_nxt;
  logic [7:0] ocr_r;
  logic [7:0] ocr_nxt;
  logic       blk_r;
  logic       blk_nxt;
  logic       cmpf_r;
  logic       cmpf_nxt;
  logic       ovff_r;
  logic       ovff_nxt;
  logic       cirq_r;
  logic       cirq_nxt;
  logic       oirq_r;
  logic       oirq_nxt;

  tc8_wgm_t   wgm;
  logic       tick;
  logic       match;
  logic       cmp_ev;
  logic       ovf_set;
  logic       ovf_ev;

  tc8_if      ifc ();

  // ********************************************
  // Submodules
  // ********************************************
  tc8_clksel i_tc8_clksel (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ck       (ifc)
  );

  tc8_wavegen i_tc8_wavegen (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .wv       (ifc)
  );

  assign wgm  = tc8_wgm_t'(waveform_mode);
  assign tick = ifc.tick;

  assign match = (cnt_r == ocr_r);
  // match blocked on tick after a counter write
  assign cmp_ev = tick && match && !blk_r;
  assign ovf_ev = tick && ovf_set;

  assign ifc.cmp_ev    = cmp_ev;
  assign ifc.force_ev  = force_compare_strobe && !tc8_is_pwm(wgm);
  assign ifc.at_max    = (cnt_r == TC8_MAX);
  assign ifc.dir       = dir_r;
  assign ifc.wgm       = wgm;
  assign ifc.com       = tc8_com_t'(compare_output_mode);
  assign ifc.cs        = clock_source_select;
  assign ifc.async_sel = async_clock_select;
  assign ifc.xtal      = crystal_pin_in;

  // ********************************************
  // Counter unit
  // ********************************************
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    ovf_set = 1'b0;
    // per-tick clear, count up or count down
    if (tick) begin
      unique case (wgm)
        // free-running up count, overflow at wrap
        TC8_WGM_NORMAL, TC8_WGM_FAST: begin
          cnt_nxt = cnt_r + TC8_ONE;
          dir_nxt = TC8_DIR_UP;
          ovf_set = (cnt_r == TC8_MAX);
        end
        TC8_WGM_CLRMATCH: begin
          cnt_nxt = (match && !blk_r) ? TC8_BOTTOM : cnt_r + TC8_ONE;
          dir_nxt = TC8_DIR_UP;
          ovf_set = (cnt_r == TC8_MAX);
        end
        // direction turns at max and at bottom
        TC8_WGM_PHASE: begin
          if (dir_r == TC8_DIR_UP) begin
            if (cnt_r == TC8_MAX) begin
              dir_nxt = TC8_DIR_DOWN;
              cnt_nxt = cnt_r - TC8_ONE;
            end else begin
              cnt_nxt = cnt_r + TC8_ONE;
            end
          end else if (cnt_r == TC8_BOTTOM) begin
            dir_nxt = TC8_DIR_UP;
            cnt_nxt = cnt_r + TC8_ONE;
            // overflow at bottom in phase mode
            ovf_set = 1'b1;
          end else begin
            cnt_nxt = cnt_r - TC8_ONE;
          end
        end
      endcase
    end
    if (counter_wr_en) begin
      cnt_nxt = counter_wr_data;
    end
    blk_nxt = counter_wr_en ? 1'b1 : (tick ? 1'b0 : blk_r);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= TC8_CNT_RST;
      dir_r <= TC8_DIR_UP;
      blk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      blk_r <= blk_nxt;
    end
  end

  // ********************************************
  // Compare value and buffer
  // ********************************************
  always_comb begin
    buf_nxt = compare_wr_en ? compare_wr_data : buf_r;
    ocr_nxt = ocr_r;
    // PWM compare reloads at top only, avoiding odd pulses
    if (!tc8_is_pwm(wgm)) begin
      ocr_nxt = buf_nxt;
    end else if (tick && cnt_r == TC8_MAX) begin
      ocr_nxt = buf_r;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_r <= TC8_CMP_RST;
      ocr_r <= TC8_CMP_RST;
    end else begin
      buf_r <= buf_nxt;
      ocr_r <= ocr_nxt;
    end
  end

  // ********************************************
  // Flags and requests
  // ********************************************
  always_comb begin
    cmpf_nxt = cmp_ev ||
               (cmpf_r && !(compare_flag_clr || compare_irq_ack));
    ovff_nxt = ovf_ev ||
               (ovff_r && !(overflow_flag_clr || overflow_irq_ack));
    cirq_nxt = cmpf_nxt && compare_irq_enable;
    oirq_nxt = ovff_nxt && overflow_irq_enable;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmpf_r <= 1'b0;
      ovff_r <= 1'b0;
      cirq_r <= 1'b0;
      oirq_r <= 1'b0;
    end else begin
      cmpf_r <= cmpf_nxt;
      ovff_r <= ovff_nxt;
      cirq_r <= cirq_nxt;
      oirq_r <= oirq_nxt;
    end
  end

  assign counter_value      = cnt_r;
  assign compare_value      = buf_r;
  assign compare_match_flag = cmpf_r;
  assign overflow_flag      = ovff_r;
  assign compare_irq        = cirq_r;
  assign overflow_irq       = oirq_r;
  assign compare_output_pin = ifc.oc;

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  cnt_write_a:
    assert property (counter_wr_en |=> cnt_r == $past(counter_wr_data))
    else $error("Counter write lost");

  stop_hold_a:
    assert property ((clock_source_select == TC8_CS_STOP
      && !counter_wr_en) |=> $stable(cnt_r))
    else $error("Counter moved while stopped");

  normal_wrap_a:
    assert property ((tick && wgm == TC8_WGM_NORMAL && cnt_r == TC8_MAX
      && !counter_wr_en) |=> (cnt_r == TC8_BOTTOM && ovff_r))
    else $error("Normal wrap or overflow wrong");

  match_clear_a:
    assert property ((tick && wgm == TC8_WGM_CLRMATCH && match && !blk_r
      && !counter_wr_en) |=> cnt_r == TC8_BOTTOM)
    else $error("Counter not cleared on match");

  flag_set_a:
    assert property ((tick && match && !blk_r) |=> cmpf_r)
    else $error("Compare flag not set after match");

  write_block_a:
    assert property ((counter_wr_en && !cmpf_r && !cmp_ev)
      ##1 (tick && !counter_wr_en) |=> !cmpf_r)
    else $error("Match not blocked after counter write");

  irq_mask_a:
    assert property (cirq_r == (cmpf_r && $past(compare_irq_enable)))
    else $error("Compare request not flag and enable");

  flag_clear_a:
    assert property ((compare_flag_clr && !cmp_ev) |=> !cmpf_r)
    else $error("Compare flag survived write one");

  ovf_ack_a:
    assert property ((overflow_irq_ack && !ovf_ev) |=> !ovff_r)
    else $error("Overflow flag survived service");

  svc_clear_a:
    assert property ((compare_irq_ack && !cmp_ev) |=> !cmpf_r)
    else $error("Compare flag survived service");

  phase_turn_a:
    assert property ((tick && wgm == TC8_WGM_PHASE && dir_r == TC8_DIR_UP
      && cnt_r == TC8_MAX && !counter_wr_en)
      |=> (dir_r == TC8_DIR_DOWN && cnt_r == TC8_MAX - TC8_ONE))
    else $error("Phase mode failed to turn at max");

  ctc_cycle_c: cover property (tick && wgm == TC8_WGM_CLRMATCH && cmp_ev);
  phase_bot_c: cover property (ovf_ev && wgm == TC8_WGM_PHASE);
  force_c:     cover property (ifc.force_ev && !cmp_ev);
  irq_c:       cover property (cirq_r ##1 compare_irq_ack);

endmodule // tc8_timer

/* File: design/tc8_wavegen.sv */
// Waveform generator driving the compare output level
`timescale 1ns/1ps
module tc8_wavegen
  import tc8_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  tc8_if.wav       wv
);

  logic oc_r;
  logic oc_nxt;

  always_comb begin
    oc_nxt = oc_r;
    if (!tc8_is_pwm(wv.wgm)) begin
      if (wv.cmp_ev || wv.force_ev) begin
        unique case (wv.com)
          TC8_COM_OFF:    oc_nxt = oc_r;
          TC8_COM_TOGGLE: oc_nxt = ~oc_r;
          TC8_COM_CLEAR:  oc_nxt = 1'b0;
          TC8_COM_SET:    oc_nxt = 1'b1;
        endcase
      end
    end else if (wv.wgm == TC8_WGM_FAST) begin
      if (wv.cmp_ev && wv.com == TC8_COM_CLEAR) begin
        oc_nxt = 1'b0;
      end else if (wv.cmp_ev && wv.com == TC8_COM_SET) begin
        oc_nxt = 1'b1;
      end
      // wrap to bottom wins, so a compare at max holds level
      if (wv.tick && wv.at_max && wv.com == TC8_COM_CLEAR) begin
        oc_nxt = 1'b1;
      end else if (wv.tick && wv.at_max && wv.com == TC8_COM_SET) begin
        oc_nxt = 1'b0;
      end
    end else if (wv.cmp_ev) begin
      if (wv.com == TC8_COM_CLEAR) begin
        oc_nxt = (wv.dir == TC8_DIR_DOWN);
      end else if (wv.com == TC8_COM_SET) begin
        oc_nxt = (wv.dir == TC8_DIR_UP);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oc_r <= 1'b0;
    end else begin
      oc_r <= oc_nxt;
    end
  end

  assign wv.oc = oc_r;

  force_toggle_a:
    assert property (@(posedge core_clk) disable iff (!reset_n)
      (wv.force_ev && !wv.cmp_ev && wv.com == TC8_COM_TOGGLE)
      |=> (oc_r != $past(oc_r)))
    else $error("Forced compare did not toggle output");

endmodule // tc8_wavegen

/* File: testbench/tc8_timer_tb.sv */
// Self-checking bench for the 8-bit timer/counter top
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("BAD %0t %s", $time, msg); \
  end \
end

module tc8_timer_tb;
  import tc8_pkg::*;

  logic       core_clk;
  logic       reset_n;
  logic [1:0] waveform_mode;
  logic [1:0] compare_output_mode;
  logic [2:0] clock_source_select;
  logic       async_clock_select;
  logic       crystal_pin_in;
  logic       compare_irq_enable;
  logic       overflow_irq_enable;
  logic       force_compare_strobe;
  logic       counter_wr_en;
  logic [7:0] counter_wr_data;
  logic       compare_wr_en;
  logic [7:0] compare_wr_data;
  logic       compare_flag_clr;
  logic       overflow_flag_clr;
  logic       compare_irq_ack;
  logic       overflow_irq_ack;
  logic [7:0] counter_value;
  logic [7:0] compare_value;
  logic       compare_match_flag;
  logic       overflow_flag;
  logic       compare_irq;
  logic       overflow_irq;
  logic       compare_output_pin;
  int         mismatches;
  int         n_tests;

  tc8_timer i_tc8_timer (
    .core_clk             (core_clk),
    .reset_n              (reset_n),
    .waveform_mode        (waveform_mode),
    .compare_output_mode  (compare_output_mode),
    .clock_source_select  (clock_source_select),
    .async_clock_select   (async_clock_select),
    .crystal_pin_in       (crystal_pin_in),
    .compare_irq_enable   (compare_irq_enable),
    .overflow_irq_enable  (overflow_irq_enable),
    .force_compare_strobe (force_compare_strobe),
    .counter_wr_en        (counter_wr_en),
    .counter_wr_data      (counter_wr_data),
    .compare_wr_en        (compare_wr_en),
    .compare_wr_data      (compare_wr_data),
    .compare_flag_clr     (compare_flag_clr),
    .overflow_flag_clr    (overflow_flag_clr),
    .compare_irq_ack      (compare_irq_ack),
    .overflow_irq_ack     (overflow_irq_ack),
    .counter_value        (counter_value),
    .compare_value        (compare_value),
    .compare_match_flag   (compare_match_flag),
    .overflow_flag        (overflow_flag),
    .compare_irq          (compare_irq),
    .overflow_irq         (overflow_irq),
    .compare_output_pin   (compare_output_pin)
  );

  // ****************************************
  // Clock and helpers
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr_cnt(input logic [7:0] d);
    @(negedge core_clk);
    counter_wr_en   = 1'b1;
    counter_wr_data = d;
    @(negedge core_clk);
    counter_wr_en   = 1'b0;
  endtask

  task automatic wr_cmp(input logic [7:0] d);
    @(negedge core_clk);
    compare_wr_en   = 1'b1;
    compare_wr_data = d;
    @(negedge core_clk);
    compare_wr_en   = 1'b0;
  endtask

  // Bounded wait; a hang ends the run with a failure
  task automatic wait_cnt(input logic [7:0] v);
    for (int i = 0; i < 600; i++) begin
      @(negedge core_clk);
      if (counter_value === v) return;
    end
    mismatches++;
    $display("BAD %0t counter wait timed out", $time);
    summarize();
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_normal();
    overflow_irq_enable = 1'b1;
    clock_source_select = 3'h1;
    wr_cnt(8'hfd);
    `CHK(counter_value, 8'hfd, "write lost to count")
    wait_cnt(TC8_BOTTOM);
    `CHK(overflow_flag, 1'b1, "no overflow at wrap")
    `CHK(overflow_irq, 1'b1, "no overflow request")
    overflow_irq_ack    = 1'b1;
    overflow_irq_enable = 1'b0;
    tick(1);
    overflow_irq_ack    = 1'b0;
    `CHK(overflow_flag, 1'b0, "ack kept overflow flag")
    `CHK(overflow_irq, 1'b0, "request outlived flag")
    wait_cnt(TC8_BOTTOM);
    `CHK(overflow_flag, 1'b1, "second overflow missing")
    `CHK(overflow_irq, 1'b0, "masked request seen")
    overflow_flag_clr = 1'b1;
    tick(1);
    overflow_flag_clr = 1'b0;
    `CHK(overflow_flag, 1'b0, "clear kept overflow flag")
    clock_source_select = TC8_CS_STOP;
    wr_cnt(8'h33);
    tick(5);
    `CHK(counter_value, 8'h33, "stopped counter moved")
    $display("done normal");
  endtask

  task automatic t_ctc();
    compare_irq_enable  = 1'b1;
    compare_output_mode = 2'h1;
    waveform_mode       = 2'h2;
    compare_flag_clr    = 1'b1;
    wr_cmp(8'h02);
    compare_flag_clr    = 1'b0;
    wr_cnt(8'h00);
    `CHK(compare_value, 8'h02, "compare write lost")
    clock_source_select = 3'h1;
    wait_cnt(8'h02);
    tick(1);
    `CHK(counter_value, 8'h00, "no clear on match")
    `CHK(compare_match_flag, 1'b1, "flag not set")
    `CHK(compare_irq, 1'b1, "no compare request")
    `CHK(compare_output_pin, 1'b1, "no toggle on match")
    compare_irq_ack = 1'b1;
    tick(1);
    compare_irq_ack = 1'b0;
    `CHK(compare_match_flag, 1'b0, "ack kept flag")
    `CHK(compare_irq, 1'b0, "request outlived flag")
    compare_irq_enable = 1'b0;
    wait_cnt(8'h00);
    `CHK(compare_match_flag, 1'b1, "flag not set again")
    `CHK(compare_irq, 1'b0, "masked request seen")
    `CHK(compare_output_pin, 1'b0, "second toggle missing")
    compare_flag_clr = 1'b1;
    tick(1);
    compare_flag_clr = 1'b0;
    `CHK(compare_match_flag, 1'b0, "write-one kept flag")
    clock_source_select = TC8_CS_STOP;
    $display("done clear on match");
  endtask

  task automatic t_block();
    waveform_mode       = 2'h0;
    compare_output_mode = 2'h0;
    wr_cmp(8'h40);
    wr_cnt(8'h40);
    clock_source_select = 3'h1;
    tick(3);
    `CHK(compare_match_flag, 1'b0, "match not blocked")
    `CHK(counter_value, 8'h43, "count wrong")
    wr_cnt(8'h3e);
    tick(2);
    `CHK(compare_match_flag, 1'b0, "early match")
    tick(1);
    `CHK(compare_match_flag, 1'b1, "match missed")
    clock_source_select = TC8_CS_STOP;
    $display("done block");
  endtask

  task automatic t_force();
    logic [1:0] m[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic       e[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    compare_flag_clr = 1'b1;
    wr_cnt(8'h77);
    compare_flag_clr = 1'b0;
    for (int i = 0; i < 4; i++) begin
      compare_output_mode  = m[i];
      force_compare_strobe = 1'b1;
      tick(1);
      force_compare_strobe = 1'b0;
      `CHK(compare_output_pin, e[i], "forced level wrong")
      tick(1);
    end
    `CHK(compare_match_flag, 1'b0, "force set flag")
    `CHK(counter_value, 8'h77, "force moved counter")
    // Strobe must be ignored in the PWM modes
    waveform_mode        = 2'h3;
    force_compare_strobe = 1'b1;
    tick(1);
    force_compare_strobe = 1'b0;
    `CHK(compare_output_pin, 1'b0, "force acted in PWM")
    $display("done force");
  endtask

  task automatic t_phase();
    waveform_mode       = 2'h1;
    compare_output_mode = 2'h0;
    wr_cnt(8'hfe);
    clock_source_select = 3'h1;
    wait_cnt(TC8_MAX);
    tick(1);
    `CHK(counter_value, 8'hfe, "no turn at top")
    tick(1);
    `CHK(counter_value, 8'hfd, "not counting down")
    clock_source_select = TC8_CS_STOP;
    $display("done phase");
  endtask

  task automatic t_async();
    waveform_mode       = 2'h0;
    wr_cnt(8'h10);
    async_clock_select  = 1'b1;
    clock_source_select = 3'h1;
    tick(6);
    `CHK(counter_value, 8'h10, "core clock ticked")
    repeat (4) begin
      crystal_pin_in = 1'b1;
      tick(3);
      crystal_pin_in = 1'b0;
      tick(3);
    end
    tick(8);
    `CHK(counter_value, 8'h14, "crystal edges lost")
    clock_source_select = TC8_CS_STOP;
    async_clock_select  = 1'b0;
    $display("done async");
  endtask

  // Fast PWM, divide by 8, buffered compare reloaded at max
  task automatic t_fast();
    int n;
    n = 0;
    waveform_mode       = 2'h3;
    compare_output_mode = 2'h2;
    wr_cmp(8'h05);
    wr_cnt(8'hfe);
    `CHK(compare_value, 8'h05, "buffer not shown")
    clock_source_select = 3'h2;
    wait_cnt(TC8_MAX);
    while (counter_value === TC8_MAX && n < 20) begin
      tick(1);
      n++;
    end
    `CHK(n, 8, "prescaled tick spacing")
    `CHK(counter_value, TC8_BOTTOM, "no wrap at max")
    `CHK(compare_output_pin, 1'b1, "no set at bottom")
    `CHK(overflow_flag, 1'b1, "no overflow at max")
    wait_cnt(8'h06);
    `CHK(compare_output_pin, 1'b0, "no clear on match")
    `CHK(compare_match_flag, 1'b1, "buffered compare unused")
    clock_source_select = TC8_CS_STOP;
    $display("done fast");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    mismatches           = 0;
    n_tests              = 0;
    reset_n              = 1'b0;
    {waveform_mode, compare_output_mode, clock_source_select} = 7'h00;
    {async_clock_select, crystal_pin_in} = 2'h0;
    {compare_irq_enable, overflow_irq_enable} = 2'h0;
    force_compare_strobe = 1'b0;
    {counter_wr_en, compare_wr_en} = 2'h0;
    counter_wr_data      = 8'h00;
    compare_wr_data      = 8'h00;
    {compare_flag_clr, overflow_flag_clr} = 2'h0;
    {compare_irq_ack, overflow_irq_ack} = 2'h0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    `CHK({counter_value, compare_value, compare_match_flag, overflow_flag,
          compare_irq, overflow_irq, compare_output_pin}, 21'h0,
         "reset state")
    t_normal();
    t_ctc();
    t_block();
    t_force();
    t_phase();
    t_async();
    t_fast();
    summarize();
  end

endmodule // tc8_timer_tb
